// ---- nvda_map.vh ----
// register offsets, control field positions and timing counts
`ifndef NVDA_MAP_VH
`define NVDA_MAP_VH
// i/o addresses of the access registers
`define NVDA_ADDR_CTRL       6'h1C
`define NVDA_ADDR_DATA       6'h1D
`define NVDA_ADDR_ADDR       6'h1E
// control register fields
`define NVDA_BIT_READ        0
`define NVDA_BIT_PROG        1
`define NVDA_BIT_ARM         2
`define NVDA_BIT_RDYIE       3
`define NVDA_BIT_MODE_LO     4
`define NVDA_BIT_MODE_HI     5
// programming modes
`define NVDA_MODE_ATOMIC     2'h0
`define NVDA_MODE_ERASE      2'h1
`define NVDA_MODE_WRITE      2'h2
`define NVDA_MODE_RSVD       2'h3
// mode reset value and erased byte value
`define NVDA_MODE_RST        2'h0
`define NVDA_ERASED_BYTE     8'hFF
// timing
`define NVDA_CLK_HZ          10000000
`define NVDA_T_ATOMIC_US     3400
`define NVDA_T_SPLIT_US      1800
`define NVDA_CYC_ATOMIC      ((`NVDA_T_ATOMIC_US * (`NVDA_CLK_HZ / 1000000)))
`define NVDA_CYC_SPLIT       ((`NVDA_T_SPLIT_US * (`NVDA_CLK_HZ / 1000000)))
`define NVDA_ARM_CYC         4
`define NVDA_READ_STALL      4
`define NVDA_PROG_STALL      2
`endif

// ---- nvda_eeprom_access.v ----
// data eeprom access registers, read path and self-timed programming
//
// Behaviour
// - own 64-byte store, bytewise read and write
// - linear byte address 0 to 63
// - address bits 5..0 rw, 7..6 read zero
// - write programs data register into addressed byte
// - read loads data register from addressed byte
// - read stalls cpu four cycles
// - write start stalls cpu two cycles
// - self-timed programming, busy bit readable
// - programming only after arm-then-enable sequence
// - registers sit in cpu i/o space
// - mode field selects atomic, erase, write timing
// - arm then enable within four cycles, arm self-clears
// - enable stays set until programming time elapses
// - read strobe fetches; busy blocks reads and address
`include "nvda_map.vh"
module nvda_eeprom_access #(
	parameter DEPTH      = 64,
	parameter AW         = 6,
	parameter CYC_ATOMIC = `NVDA_CYC_ATOMIC,
	parameter CYC_SPLIT  = `NVDA_CYC_SPLIT
) (
	// clock and reset
	input  wire       clk_i,
	input  wire       sys_rst_i,
	// cpu i/o register port
	input  wire [5:0] io_addr_i,
	input  wire       io_wr_i,
	input  wire       io_rd_i,
	input  wire [7:0] io_wdata_i,
	output reg  [7:0] io_rdata_o,
	// cpu control
	output reg        cpu_stall_o,
	output reg        nv_ready_o
);

	////////////////////////////////////////////////////////////////////
	// storage and registers

	reg [7:0]  mem [0:DEPTH-1];
	reg [AW-1:0] nv_address_bits;
	reg [7:0]  nv_data_bits;
	reg [1:0]  nv_mode;
	reg        nv_ready_ie;
	reg        nv_program_arm;
	reg        nv_program_enable;
	reg [2:0]  arm_cnt;
	reg [2:0]  stall_cnt;
	reg [31:0] prog_cnt;
	reg [1:0]  act_mode;
	reg [AW-1:0] act_addr;
	reg [7:0]  act_data;
	reg          next_arm;
	reg [2:0]    next_arm_cnt;
	reg          next_enable;
	reg [31:0]   next_prog_cnt;
	reg          next_stall;
	reg [2:0]    next_stall_cnt;
	reg [7:0]    next_rdata;
	reg          next_ready;

	// counter loads, cut to the counter width on purpose
	localparam [2:0]  ARM_LOAD = `NVDA_ARM_CYC;
	localparam [2:0]  RD_LOAD  = `NVDA_READ_STALL - 1;
	localparam [2:0]  PG_LOAD  = `NVDA_PROG_STALL - 1;
	localparam [31:0] LAST_CYC = 32'h0000_0001;

	// exact match of one i/o register address
	function io_hit;
		input [5:0] a;
		input [5:0] target;
		begin
			io_hit = (a == target);
		end
	endfunction

	// strobes decoded per register; other writes are ignored, other reads return zero
	wire wr_ctrl = io_wr_i && io_hit(io_addr_i, `NVDA_ADDR_CTRL);
	wire wr_data = io_wr_i && io_hit(io_addr_i, `NVDA_ADDR_DATA);
	wire wr_addr = io_wr_i && io_hit(io_addr_i, `NVDA_ADDR_ADDR);
	wire rd_ctrl = io_rd_i && io_hit(io_addr_i, `NVDA_ADDR_CTRL);
	wire rd_data = io_rd_i && io_hit(io_addr_i, `NVDA_ADDR_DATA);
	wire rd_addr = io_rd_i && io_hit(io_addr_i, `NVDA_ADDR_ADDR);
	wire busy    = nv_program_enable;

	// program start needs arm still live
	wire prog_go = wr_ctrl && io_wdata_i[`NVDA_BIT_PROG] && !busy &&
		nv_program_arm && (nv_mode != `NVDA_MODE_RSVD);
	// read refused while programming
	wire read_go = wr_ctrl && io_wdata_i[`NVDA_BIT_READ] && !busy;
	wire prog_done = busy && (prog_cnt == 32'h0000_0001);

	function [31:0] mode_cycles;
		input [1:0] m;
		begin
			if (m == `NVDA_MODE_ATOMIC)
				mode_cycles = CYC_ATOMIC;
			else
				mode_cycles = CYC_SPLIT;
		end
	endfunction

	wire [7:0] ctrl_view = {2'b00, nv_mode, nv_ready_ie, nv_program_arm,
		nv_program_enable, 1'b0};

	////////////////////////////////////////////////////////////////////
	// register writes

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			nv_address_bits <= {AW{1'b0}};
			nv_data_bits    <= 8'h00;
			nv_mode         <= `NVDA_MODE_RST;
			nv_ready_ie     <= 1'b0;
		end else begin
			if (wr_addr && !busy)
				nv_address_bits <= io_wdata_i[AW-1:0];
			if (read_go)
				nv_data_bits <= mem[nv_address_bits];
			else if (wr_data)
				nv_data_bits <= io_wdata_i;
			if (wr_ctrl) begin
				nv_ready_ie <= io_wdata_i[`NVDA_BIT_RDYIE];
				if (!busy)
					nv_mode <= io_wdata_i[`NVDA_BIT_MODE_HI:`NVDA_BIT_MODE_LO];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// arm window

	// a fresh arm write wins over the window running out
	always @* begin
		next_arm     = nv_program_arm;
		next_arm_cnt = arm_cnt;
		if (wr_ctrl && io_wdata_i[`NVDA_BIT_ARM] &&
			!io_wdata_i[`NVDA_BIT_PROG]) begin
			next_arm     = 1'b1;
			next_arm_cnt = ARM_LOAD;
		end else if (prog_go || arm_cnt == 3'h1) begin
			next_arm     = 1'b0;
			next_arm_cnt = 3'h0;
		end else if (arm_cnt != 3'h0) begin
			next_arm_cnt = arm_cnt - 3'h1;
		end
	end

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			nv_program_arm <= 1'b0;
			arm_cnt        <= 3'h0;
		end else begin
			nv_program_arm <= next_arm;
			arm_cnt        <= next_arm_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// self-timed programming

	// start cannot meet done: a start needs the store idle
	always @* begin
		next_enable   = nv_program_enable;
		next_prog_cnt = prog_cnt;
		if (prog_go) begin
			next_enable   = 1'b1;
			next_prog_cnt = mode_cycles(nv_mode);
		end else if (prog_done) begin
			next_enable   = 1'b0;
			next_prog_cnt = 32'h0000_0000;
		end else if (busy) begin
			next_prog_cnt = prog_cnt - LAST_CYC;
		end
	end

	// operands latched at start, so later writes cannot leak in
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			nv_program_enable <= 1'b0;
			prog_cnt          <= 32'h0000_0000;
			act_mode          <= `NVDA_MODE_ATOMIC;
			act_addr          <= {AW{1'b0}};
			act_data          <= 8'h00;
		end else begin
			nv_program_enable <= next_enable;
			prog_cnt          <= next_prog_cnt;
			if (prog_go) begin
				act_mode <= nv_mode;
				act_addr <= nv_address_bits;
				act_data <= nv_data_bits;
			end
		end
	end

	// array update at end of programming time
	always @(posedge clk_i) begin
		if (prog_done) begin
			case (act_mode)
			`NVDA_MODE_ATOMIC: mem[act_addr] <= act_data;
			`NVDA_MODE_ERASE:  mem[act_addr] <= `NVDA_ERASED_BYTE;
			`NVDA_MODE_WRITE:  mem[act_addr] <= mem[act_addr] & act_data;
			default:           mem[act_addr] <= mem[act_addr];
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// cpu stall

	// stall counts the remaining halted cycles after the first
	always @* begin
		next_stall     = 1'b0;
		next_stall_cnt = stall_cnt;
		if (read_go) begin
			next_stall     = 1'b1;
			next_stall_cnt = RD_LOAD;
		end else if (prog_go) begin
			next_stall     = 1'b1;
			next_stall_cnt = PG_LOAD;
		end else if (stall_cnt != 3'h0) begin
			next_stall     = 1'b1;
			next_stall_cnt = stall_cnt - 3'h1;
		end
	end

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			stall_cnt   <= 3'h0;
			cpu_stall_o <= 1'b0;
		end else begin
			stall_cnt   <= next_stall_cnt;
			cpu_stall_o <= next_stall;
		end
	end

	////////////////////////////////////////////////////////////////////
	// i/o read-back

	// read data holds until the next read strobe
	always @* begin
		next_rdata = io_rdata_o;
		if (rd_ctrl)
			next_rdata = ctrl_view;
		else if (rd_data)
			next_rdata = nv_data_bits;
		else if (rd_addr)
			next_rdata = {{(8-AW){1'b0}}, nv_address_bits};
		else if (io_rd_i)
			next_rdata = 8'h00;
	end

	// ready level drops in the same cycle a start is taken
	always @* begin
		next_ready = nv_ready_ie && !busy && !prog_go;
	end

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			io_rdata_o <= 8'h00;
			nv_ready_o <= 1'b0;
		end else begin
			io_rdata_o <= next_rdata;
			nv_ready_o <= next_ready;
		end
	end

endmodule

// ---- nvda_access_monitor.sv ----
// port checker for the eeprom access block
`include "nvda_map.vh"
module nvda_access_chk (
	input wire       clk_i, sys_rst_i, io_wr_i, io_rd_i,
	input wire [5:0] io_addr_i,
	input wire [7:0] io_wdata_i, io_rdata_o,
	input wire       cpu_stall_o, nv_ready_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	wire ctl_wr = io_wr_i && io_addr_i == `NVDA_ADDR_CTRL;
	wire rd_go = ctl_wr && io_wdata_i[0];
	wire pg_go = ctl_wr && io_wdata_i[1];
	chk_rd_stall: assert property ($rose(cpu_stall_o) && $past(rd_go)
		|-> cpu_stall_o[*4] ##1 !cpu_stall_o) else $error("read stall");
	chk_pg_stall: assert property ($rose(cpu_stall_o) && $past(pg_go)
		|-> cpu_stall_o[*2] ##1 !cpu_stall_o) else $error("write stall");
	chk_stall_src: assert property ($rose(cpu_stall_o) |-> $past(ctl_wr))
		else $error("stall without cause");
	chk_rdata_hold: assert property (!$past(io_rd_i) |-> $stable(io_rdata_o))
		else $error("read data moved");
	chk_unmapped_zero: assert property (io_rd_i && io_addr_i < `NVDA_ADDR_CTRL
		|=> io_rdata_o == 8'h00) else $error("unmapped read");
	chk_addr_top: assert property (io_rd_i && io_addr_i == `NVDA_ADDR_ADDR
		|=> io_rdata_o[7:6] == 2'h0) else $error("address top bits");
	chk_ctrl_rsvd: assert property (io_rd_i && io_addr_i == `NVDA_ADDR_CTRL
		|=> io_rdata_o[7:6] == 2'h0 && !io_rdata_o[0]) else $error("control bits");
	chk_ready_off: assert property (ctl_wr && !io_wdata_i[3]
		|=> ##[0:1] !nv_ready_o) else $error("ready stays up");
endmodule
bind nvda_eeprom_access nvda_access_chk u_chk (.clk_i, .sys_rst_i, .io_wr_i,
	.io_rd_i, .io_addr_i, .io_wdata_i, .io_rdata_o, .cpu_stall_o, .nv_ready_o);

// ---- nvda_cpu_model.sv ----
// cpu-side model driving the i/o register port
module nvda_cpu_model (
	input  wire        clk_i, stall_i,
	input  wire  [7:0] rdata_i,
	output logic [5:0] addr_o = 6'h00,
	output logic       wr_o = 1'b0,
	output logic       rd_o = 1'b0,
	output logic [7:0] wdata_o = 8'h00
);
	timeunit 1ns;
	timeprecision 1ns;
	// halted cpu issues nothing
	task go;
		@(negedge clk_i);
		while (stall_i !== 1'b0)
			@(negedge clk_i);
	endtask
	task wr(input logic [5:0] a, input logic [7:0] v);
		go;
		addr_o = a;
		wdata_o = v;
		wr_o = 1'b1;
		@(negedge clk_i);
		wr_o = 1'b0;
		wdata_o = ~v;
	endtask
	task rd(input logic [5:0] a, output logic [7:0] v);
		go;
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clk_i);
		rd_o = 1'b0;
		v = rdata_i;
	endtask
endmodule

// ---- test_eeprom_data_access.sv ----
// testbench for the eeprom access block
`include "nvda_map.vh"
module test_eeprom_data_access;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	wire [5:0] io_addr_i;
	wire [7:0] io_wdata_i, io_rdata_o;
	wire io_wr_i, io_rd_i, cpu_stall_o, nv_ready_o;
	int errors = 0;
	int n_tests = 0;
	logic [7:0] d;
	always #50 clk_i = ~clk_i;
	nvda_eeprom_access #(.CYC_ATOMIC(20), .CYC_SPLIT(10)) DUT (.clk_i,
		.sys_rst_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o,
		.cpu_stall_o, .nv_ready_o);
	nvda_cpu_model cpu (.clk_i, .stall_i(cpu_stall_o), .rdata_i(io_rdata_o),
		.addr_o(io_addr_i), .wr_o(io_wr_i), .rd_o(io_rd_i), .wdata_o(io_wdata_i));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task rdchk(input logic [5:0] a, input logic [7:0] exp);
		cpu.rd(a, d);
		chk(d, exp);
	endtask
	task busychk;
		cpu.rd(`NVDA_ADDR_CTRL, d);
		chk(d & 8'h02, 8'h00);
	endtask
	// address and data loaded, then arm, then enable
	task prog(input logic [5:0] a, input logic [7:0] v, input logic [1:0] m);
		cpu.wr(`NVDA_ADDR_ADDR, {2'h0, a});
		cpu.wr(`NVDA_ADDR_DATA, v);
		cpu.wr(`NVDA_ADDR_CTRL, {2'h0, m, 4'hC});
		cpu.wr(`NVDA_ADDR_CTRL, {2'h0, m, 4'hA});
	endtask
	task wait_done;
		repeat (60) begin
			cpu.rd(`NVDA_ADDR_CTRL, d);
			if (d[1] === 1'b0)
				break;
		end
		chk(d & 8'h02, 8'h00);
		chk({7'h0, nv_ready_o}, 8'h01);
	endtask
	task fetch(input logic [7:0] exp);
		cpu.wr(`NVDA_ADDR_CTRL, 8'h09);
		rdchk(`NVDA_ADDR_DATA, exp);
	endtask
	task summarize;
		$display("errors %0d n_tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#400000;
		errors++;
		summarize;
	end
	initial begin
		repeat (2) @(negedge clk_i);
		sys_rst_i = 1'b0;
		rdchk(`NVDA_ADDR_CTRL, 8'h00);
		cpu.wr(`NVDA_ADDR_ADDR, 8'hFF);
		rdchk(`NVDA_ADDR_ADDR, 8'h3F);
		rdchk(6'h00, 8'h00);
		prog(6'h3F, 8'hA5, `NVDA_MODE_ATOMIC);
		rdchk(`NVDA_ADDR_CTRL, 8'h0A);
		chk({7'h0, nv_ready_o}, 8'h00);
		cpu.wr(`NVDA_ADDR_ADDR, 8'h05);
		rdchk(`NVDA_ADDR_ADDR, 8'h3F);
		cpu.wr(`NVDA_ADDR_CTRL, 8'h09);
		rdchk(`NVDA_ADDR_DATA, 8'hA5);
		wait_done;
		fetch(8'hA5);
		prog(6'h05, 8'h00, `NVDA_MODE_ERASE);
		wait_done;
		fetch(8'hFF);
		prog(6'h05, 8'h3C, `NVDA_MODE_WRITE);
		wait_done;
		fetch(8'h3C);
		prog(6'h05, 8'h00, `NVDA_MODE_RSVD);
		busychk;
		cpu.wr(`NVDA_ADDR_CTRL, 8'h02);
		busychk;
		cpu.wr(`NVDA_ADDR_CTRL, 8'h04);
		repeat (6) @(negedge clk_i);
		cpu.wr(`NVDA_ADDR_CTRL, 8'h02);
		busychk;
		fetch(8'h3C);
		summarize;
	end
endmodule
